/* design/spi_master_buffered_port.sv */
`timescale 1ns/1ns
module spi_master_buffered_port import spi_port_pkg::*; #(
  parameter int TX_DEPTH = TX_DEPTH_DEF,
  parameter int HALF_DIV = SCK_HALF_CYC
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  output logic                   irq_out,
  output logic                   serial_clock_pin_out,
  output logic                   mosi_out,
  input  wire logic              miso_in
);
  localparam int PW = (TX_DEPTH > 1) ? $clog2(TX_DEPTH) : 1;
  localparam int CW = $clog2(TX_DEPTH + 1);

  typedef struct packed {
    logic                               en;
    logic                               cke;
    logic                               idle_lvl;
    logic                               buffer_fifo_enable;
    logic [15:0]                        ctrl2;
    logic [2:0]                         irq_mode_select;
    logic [IRQ_BITS-1:0]                irq_stat;
    logic [IRQ_BITS-1:0]                irq_mask;
    logic [TX_DEPTH-1:0][WORD_BITS-1:0] mem;
    logic [PW-1:0]                      wp;
    logic [PW-1:0]                      rp;
    logic [CW-1:0]                      cnt;
    logic                               start;
    logic [WORD_BITS-1:0]               tx_word;
    logic [WORD_BITS-1:0]               rx_buf;
    logic                               rx_buffer_full_flag;
    logic                               cond_prev;
    logic                               bvalid;
    logic [1:0]                         bresp;
    logic                               rvalid;
    logic [31:0]                        rdata;
    logic [1:0]                         rresp;
  } port_s;

  port_s st;
  port_s n;

  spi_engine_if eng_if ();

  logic aw_take;
  logic ar_take;
  logic push;
  logic pop;
  logic shift_reg_empty_flag;
  logic tx_full;
  logic cond_now;
  logic [CW-1:0] cap;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == CTRL_OFS) || (a == CTRL2_OFS) || (a == STAT_OFS) ||
              (a == BUF_OFS) || (a == IRQ_STAT_OFS) || (a == IRQ_MASK_OFS);
  endfunction

  // the single rx word stands in for every rx fill level
  function automatic logic irq_cond(input logic [2:0] m, input logic rbf,
                                    input logic empty, input logic full,
                                    input logic sr_empty);
    case (m)
      IRQ_MODE_TX_SPACE:  irq_cond = !full;
      IRQ_MODE_SHIFT_END: irq_cond = sr_empty && empty;
      IRQ_MODE_TX_EMPTY:  irq_cond = empty;
      IRQ_MODE_TX_FULL:   irq_cond = full;
      default:            irq_cond = rbf;
    endcase
  endfunction

  // ------------------------------------------------------------
  // bus handshakes and fifo status
  // ------------------------------------------------------------
  // both write channels are taken together; one response outstanding at most
  assign aw_take = s_axi_awvalid_in && s_axi_wvalid_in && !st.bvalid;
  assign ar_take = s_axi_arvalid_in && !st.rvalid;
  assign cap     = st.buffer_fifo_enable ? CW'(TX_DEPTH) : CW'(1);
  assign tx_full = (st.cnt >= cap);
  assign push    = aw_take && (s_axi_awaddr_in == BUF_OFS) && s_axi_wstrb_in[0] && !tx_full;
  assign pop     = st.en && !eng_if.busy && !st.start && (st.cnt != '0);
  assign shift_reg_empty_flag = !eng_if.busy && !st.start;
  assign cond_now = irq_cond(st.irq_mode_select, st.rx_buffer_full_flag, st.cnt == '0,
                             tx_full, shift_reg_empty_flag);

  // ------------------------------------------------------------
  // register file, fifo and irq logic
  // ------------------------------------------------------------
  always_comb begin
    n = st;
    n.start = 1'b0;
    if (s_axi_bready_in) begin
      n.bvalid = 1'b0;
    end
    if (s_axi_rready_in) begin
      n.rvalid = 1'b0;
    end
    // reads, with their clearing side effects placed before any set
    if (ar_take) begin
      n.rvalid = 1'b1;
      n.rresp  = reg_hit(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
      n.rdata  = REG_RST;
      case (s_axi_araddr_in)
        CTRL_OFS: begin
          n.rdata[CTRL_EN_BIT]    = st.en;
          n.rdata[CTRL_CKE_BIT]   = st.cke;
          n.rdata[CTRL_IDLE_BIT]  = st.idle_lvl;
          n.rdata[CTRL_BUFEN_BIT] = st.buffer_fifo_enable;
        end
        CTRL2_OFS: n.rdata[15:0] = st.ctrl2;
        STAT_OFS: begin
          n.rdata[STAT_RBF_BIT]   = st.rx_buffer_full_flag;
          n.rdata[STAT_TBF_BIT]   = tx_full;
          n.rdata[STAT_MODE_LSB +: 3] = st.irq_mode_select;
          n.rdata[STAT_SHIFT_REG_EMPTY_FLAG_BIT] = shift_reg_empty_flag;
        end
        BUF_OFS: begin
          n.rdata[WORD_BITS-1:0] = st.rx_buf;
          n.rx_buffer_full_flag  = 1'b0;
        end
        IRQ_STAT_OFS: begin
          n.rdata[IRQ_BITS-1:0] = st.irq_stat;
          n.irq_stat            = '0;
        end
        IRQ_MASK_OFS: n.rdata[IRQ_BITS-1:0] = st.irq_mask;
        default: n.rdata = REG_RST;
      endcase
    end
    // writes; the framing bit is stored but steers nothing
    if (aw_take) begin
      n.bvalid = 1'b1;
      n.bresp  = reg_hit(s_axi_awaddr_in) ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_wstrb_in[0]) begin
        case (s_axi_awaddr_in)
          CTRL_OFS: begin
            n.en                 = s_axi_wdata_in[CTRL_EN_BIT];
            n.cke                = s_axi_wdata_in[CTRL_CKE_BIT];
            n.idle_lvl           = s_axi_wdata_in[CTRL_IDLE_BIT];
            n.buffer_fifo_enable = s_axi_wdata_in[CTRL_BUFEN_BIT];
          end
          CTRL2_OFS:    n.ctrl2[7:0] = s_axi_wdata_in[7:0];
          STAT_OFS:     n.irq_mode_select = s_axi_wdata_in[STAT_MODE_LSB +: 3];
          IRQ_MASK_OFS: n.irq_mask = s_axi_wdata_in[IRQ_BITS-1:0];
          default:      n.en = st.en;
        endcase
      end
      if (s_axi_wstrb_in[1] && (s_axi_awaddr_in == CTRL2_OFS)) begin
        n.ctrl2[15:8] = s_axi_wdata_in[15:8];
      end
    end
    // fifo: a full buffer silently drops the written word
    if (push) begin
      n.mem[st.wp] = s_axi_wdata_in[WORD_BITS-1:0];
      n.wp         = st.wp + PW'(1);
    end
    if (pop) begin
      n.start   = 1'b1;
      n.tx_word = st.mem[st.rp];
      n.rp      = st.rp + PW'(1);
    end
    n.cnt = st.cnt + CW'(push) - CW'(pop);
    // completion sets win over a read clear in the same cycle
    if (eng_if.done) begin
      n.rx_buf              = eng_if.rx_data;
      n.rx_buffer_full_flag = 1'b1;
      n.irq_stat[IRQ_DONE_BIT] = 1'b1;
    end
    n.cond_prev = cond_now;
    if (st.buffer_fifo_enable) begin
      if (cond_now && !st.cond_prev) begin
        n.irq_stat[IRQ_SERIAL_BIT] = 1'b1;
      end
    end else if (eng_if.done) begin
      n.irq_stat[IRQ_SERIAL_BIT] = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

  // ------------------------------------------------------------
  // outputs and the shift engine
  // ------------------------------------------------------------
  assign s_axi_awready_out = aw_take;
  assign s_axi_wready_out  = aw_take;
  assign s_axi_bvalid_out  = st.bvalid;
  assign s_axi_bresp_out   = st.bresp;
  assign s_axi_arready_out = ar_take;
  assign s_axi_rvalid_out  = st.rvalid;
  assign s_axi_rdata_out   = st.rdata;
  assign s_axi_rresp_out   = st.rresp;
  assign irq_out           = |(st.irq_stat & st.irq_mask);
  assign eng_if.start      = st.start;
  assign eng_if.tx_word    = st.tx_word;
  assign eng_if.cke        = st.cke;
  assign eng_if.idle_lvl   = st.idle_lvl;

  spi_shift_engine #(.HALF_DIV(HALF_DIV)) u_engine (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .eng        (eng_if),
    .miso_in    (miso_in),
    .sck_out    (serial_clock_pin_out),
    .mosi_out   (mosi_out)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  mode_field_a: assert property (
    aw_take && s_axi_wstrb_in[0] && s_axi_awaddr_in == STAT_OFS
    |=> st.irq_mode_select == $past(s_axi_wdata_in[STAT_MODE_LSB +: 3]))
    else $error("irq mode field not written");
  shift_end_irq_a: assert property (
    $rose(st.irq_stat[IRQ_SERIAL_BIT]) && st.buffer_fifo_enable &&
    $past(st.buffer_fifo_enable && st.irq_mode_select == IRQ_MODE_SHIFT_END)
    |-> $past(shift_reg_empty_flag && st.cnt == '0))
    else $error("shift end irq raised while bits remain");
  fifo_empty_irq_a: assert property (
    $rose(st.cnt == '0) && st.buffer_fifo_enable && $stable(st.buffer_fifo_enable) &&
    st.irq_mode_select == IRQ_MODE_TX_EMPTY && $stable(st.irq_mode_select)
    |=> st.irq_stat[IRQ_SERIAL_BIT])
    else $error("fifo empty irq missing");
  shift_reg_empty_flag_read_a: assert property (
    ar_take && s_axi_araddr_in == STAT_OFS
    |=> st.rdata[STAT_SHIFT_REG_EMPTY_FLAG_BIT] == $past(shift_reg_empty_flag) && st.rvalid)
    else $error("shift empty bit misreported");
  rbf_done_a: assert property (
    eng_if.done |=> st.rx_buffer_full_flag && st.rx_buf == $past(eng_if.rx_data))
    else $error("rx word or full flag not captured");
  legacy_irq_a: assert property (
    !st.buffer_fifo_enable && eng_if.done |=> st.irq_stat[IRQ_SERIAL_BIT])
    else $error("legacy completion irq missing");
  legacy_depth_a: assert property (
    !st.buffer_fifo_enable && $stable(st.buffer_fifo_enable) && st.cnt != '0 |-> !push)
    else $error("legacy buffer accepted a second word");

  legacy_xfer_c: cover property (!st.buffer_fifo_enable && eng_if.done);
  shift_end_c: cover property (st.irq_mode_select == IRQ_MODE_SHIFT_END &&
                               $rose(st.irq_stat[IRQ_SERIAL_BIT]));
  fifo_full_c: cover property (st.buffer_fifo_enable && tx_full);
endmodule

/* design/spi_port_pkg.sv */
package spi_port_pkg;
  // ------------------------------------------------------------
  // register map, byte addresses on the axi4-lite bus
  // ------------------------------------------------------------
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] CTRL2_OFS    = 8'h04;
  localparam logic [7:0] STAT_OFS     = 8'h08;
  localparam logic [7:0] BUF_OFS      = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_CKE_BIT   = 1;
  localparam int CTRL_IDLE_BIT  = 2;
  localparam int CTRL_BUFEN_BIT = 3;
  localparam int FRAME_EN_BIT   = 15;
  localparam int STAT_RBF_BIT   = 0;
  localparam int STAT_TBF_BIT   = 1;
  localparam int STAT_MODE_LSB  = 2;
  localparam int STAT_SHIFT_REG_EMPTY_FLAG_BIT = 7;
  localparam int IRQ_SERIAL_BIT = 0;
  localparam int IRQ_DONE_BIT   = 1;
  localparam int IRQ_BITS       = 2;

  // ------------------------------------------------------------
  // interrupt mode codes; codes 0 to 3 all follow the rx word
  // ------------------------------------------------------------
  localparam logic [2:0] IRQ_MODE_TX_SPACE  = 3'h4;
  localparam logic [2:0] IRQ_MODE_SHIFT_END = 3'h5;
  localparam logic [2:0] IRQ_MODE_TX_EMPTY  = 3'h6;
  localparam logic [2:0] IRQ_MODE_TX_FULL   = 3'h7;

  // ------------------------------------------------------------
  // reset values, bus answers, timing
  // ------------------------------------------------------------
  localparam logic [31:0] REG_RST       = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam int          WORD_BITS     = 8;
  localparam logic [3:0]  LAST_TOGGLE   = 4'hF;
  localparam int          TX_DEPTH_DEF  = 8;
  localparam int          SYS_PERIOD_NS = 10;
  localparam int          SCK_HALF_NS   = 80;
  localparam int          SCK_HALF_CYC  = (SCK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
endpackage

/* design/spi_engine_if.sv */
`timescale 1ns/1ns
interface spi_engine_if import spi_port_pkg::*; ;
  logic                 start;
  logic                 cke;
  logic                 idle_lvl;
  logic [WORD_BITS-1:0] tx_word;
  logic                 busy;
  logic                 done;
  logic [WORD_BITS-1:0] rx_data;
  modport ctrl (output start, cke, idle_lvl, tx_word, input busy, done, rx_data);
  modport eng  (input start, cke, idle_lvl, tx_word, output busy, done, rx_data);
endinterface

/* design/spi_shift_engine.sv */
`timescale 1ns/1ns
module spi_shift_engine import spi_port_pkg::*; #(
  parameter int HALF_DIV = SCK_HALF_CYC
) (
  input  wire logic   clk_sys_in,
  input  wire logic   rst_in,
  spi_engine_if.eng   eng,
  input  wire logic   miso_in,
  output logic        sck_out,
  output logic        mosi_out
);
  localparam int DW = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;

  typedef enum logic [1:0] {ENG_IDLE = 2'b01, ENG_SHIFT = 2'b10} eng_state_e;
  typedef struct packed {
    eng_state_e           state;
    logic [2:0]           sync;
    logic                 miso_f;
    logic [DW-1:0]        div;
    logic [3:0]           tog;
    logic                 sck;
    logic                 dout;
    logic [WORD_BITS-1:0] txs;
    logic [WORD_BITS-1:0] rxs;
    logic                 done;
    logic [WORD_BITS-1:0] rx_word;
  } eng_s;

  eng_s r;
  eng_s n;

  // ------------------------------------------------------------
  // shifter: even toggles are idle->active, odd ones go back
  // ------------------------------------------------------------
  always_comb begin
    n = r;
    n.done = 1'b0;
    n.sync = {r.sync[1:0], miso_in};
    // a miso change counts only once stages two and three agree
    if (r.sync[1] == r.sync[2]) begin
      n.miso_f = r.sync[2];
    end
    case (r.state)
      ENG_IDLE: begin
        n.sck = eng.idle_lvl;
        n.div = '0;
        n.tog = 4'h0;
        if (eng.start) begin
          n.state = ENG_SHIFT;
          if (eng.cke) begin
            // first bit must be on the wire before the first active edge
            n.dout = eng.tx_word[WORD_BITS-1];
            n.txs  = {eng.tx_word[WORD_BITS-2:0], 1'b0};
          end else begin
            n.txs = eng.tx_word;
          end
        end
      end
      ENG_SHIFT: begin
        if (r.div == DW'(HALF_DIV - 1)) begin
          n.div = '0;
          n.sck = ~r.sck;
          n.tog = r.tog + 4'h1;
          if (!r.tog[0]) begin
            if (eng.cke) begin
              n.rxs = {r.rxs[WORD_BITS-2:0], r.miso_f};
            end else begin
              n.dout = r.txs[WORD_BITS-1];
              n.txs  = {r.txs[WORD_BITS-2:0], 1'b0};
            end
          end else begin
            if (!eng.cke) begin
              n.rxs = {r.rxs[WORD_BITS-2:0], r.miso_f};
            end else if (r.tog != LAST_TOGGLE) begin
              // data moves on the active->idle edge
              n.dout = r.txs[WORD_BITS-1];
              n.txs  = {r.txs[WORD_BITS-2:0], 1'b0};
            end
            // completion is flagged on the closing edge, not half a bit early
            if (r.tog == LAST_TOGGLE) begin
              n.state   = ENG_IDLE;
              n.done    = 1'b1;
              n.rx_word = eng.cke ? r.rxs : {r.rxs[WORD_BITS-2:0], r.miso_f};
            end
          end
        end else begin
          n.div = r.div + DW'(1);
        end
      end
      default: begin
        n.state = ENG_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      r       <= '0;
      r.state <= ENG_IDLE;
    end else begin
      r <= n;
    end
  end

  assign sck_out     = r.sck;
  assign mosi_out    = r.dout;
  assign eng.busy    = (r.state == ENG_SHIFT);
  assign eng.done    = r.done;
  assign eng.rx_data = r.rx_word;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  idle_clock_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    r.state == ENG_IDLE ##1 r.state == ENG_IDLE |-> r.sck == $past(eng.idle_lvl))
    else $error("serial clock left idle level between transfers");
  cke_edge_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    eng.cke && $stable(eng.cke) && $changed(r.dout) |-> r.sck == eng.idle_lvl)
    else $error("data changed away from the active to idle edge");
  done_idle_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    r.done |-> r.sck == $past(eng.idle_lvl, 2) && $past(r.tog) == LAST_TOGGLE)
    else $error("transfer ended without sixteen clock toggles");
  word_done_c: cover property (@(posedge clk_sys_in) disable iff (rst_in) r.done);
endmodule

/* test/serial_slave_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// serial peripheral in slave role
// ----------------------------------------
module serial_slave_model (
  input  wire logic       sck_in,
  input  wire logic       mosi_in,
  input  wire logic       cke_in,
  input  wire logic       idle_in,
  input  wire logic [7:0] tx_byte_in,
  output logic            miso_out,
  output logic [7:0]      rx_byte_out,
  output int              rx_cnt_out
);
  logic [7:0] sreg = 8'h00;
  int         nbit = 0;
  logic       sck_seen = 1'b0;

  assign miso_out = sreg[7];

  // preload the next word while no word is in flight
  always @(tx_byte_in) begin
    if (nbit == 0) begin
      sreg = tx_byte_in;
    end
  end

  // sample edge is the leading one when cke is set, else the trailing one
  always @(sck_in) begin
    // the pin settling onto its reset level is no edge, or the bit count slips
    if (sck_in != sck_seen) begin
      if ((sck_in != idle_in) == cke_in) begin
        rx_byte_out = {rx_byte_out[6:0], mosi_in};
        nbit = (nbit == 7) ? 0 : nbit + 1;
        if (nbit == 0) begin
          rx_cnt_out++;
        end
      end else begin
        // spent bits are inverted so a late sample never sees a stale level
        sreg = (nbit == 0) ? tx_byte_in : {sreg[6:0], ~sreg[7]};
      end
    end
    sck_seen = sck_in;
  end

  initial rx_cnt_out = 0;
endmodule

/* test/tb.sv */
`timescale 1ns/1ns
module tb import spi_port_pkg::*; ;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
  logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
  logic [31:0] s_axi_wdata_in = '0, s_axi_rdata_out, rv;
  logic [3:0]  s_axi_wstrb_in = 4'hF;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rr;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, irq_out, serial_clock_pin_out, mosi_out, miso_in;
  logic        s_cke = 1'b0, s_idle = 1'b0;
  logic [7:0]  s_tx = 8'h00, s_rx;
  logic [15:0] seed = 16'h7C7A;
  int          s_cnt, c0, n_edge = 0, checks = 0, n_mismatch = 0;

  spi_master_buffered_port i_dut (.clk_sys_in, .rst_in, .s_axi_awaddr_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
    .s_axi_rvalid_out, .s_axi_rready_in, .irq_out, .serial_clock_pin_out, .mosi_out, .miso_in);
  serial_slave_model i_slave (.sck_in(serial_clock_pin_out), .mosi_in(mosi_out),
    .cke_in(s_cke), .idle_in(s_idle), .tx_byte_in(s_tx), .miso_out(miso_in),
    .rx_byte_out(s_rx), .rx_cnt_out(s_cnt));

  // ----------------------------------------
  // clock, edge count, watchdog
  // ----------------------------------------
  initial forever #5 clk_sys_in = ~clk_sys_in;
  always @(serial_clock_pin_out) n_edge++;
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    n_mismatch++;
    wrap_up();
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] stat_exp(input logic rbf, input logic [2:0] m);
    return {24'h0, 1'b1, 2'h0, m, 1'b0, rbf};
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  // a write offers address and data together and holds them until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys_in);
    {s_axi_awaddr_in, s_axi_wdata_in} <= {a, d};
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
    do @(posedge clk_sys_in); while (s_axi_awready_out !== 1'b1);
    {s_axi_awvalid_in, s_axi_wvalid_in} <= 2'h0;
    do @(posedge clk_sys_in); while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 1'b0;
    chk("bresp", er, s_axi_bresp_out);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    s_axi_araddr_in <= a;
    {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
    do @(posedge clk_sys_in); while (s_axi_arready_out !== 1'b1);
    s_axi_arvalid_in <= 1'b0;
    do @(posedge clk_sys_in); while (s_axi_rvalid_out !== 1'b1);
    s_axi_rready_in <= 1'b0;
    {rv, rr} = {s_axi_rdata_out, s_axi_rresp_out};
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(what, e, rv);
    chk("rresp", RESP_OKAY, rr);
  endtask
  // one legacy word; host waits for the flag, or for the slave word count when masked, then for the idle clock
  task automatic xfer(input logic masked);
    logic [7:0] tx;
    seed = lfsr(seed);
    tx = seed[7:0];
    s_tx <= seed[15:8];
    // an idle level change from the last control write lands one edge late
    @(posedge clk_sys_in);
    c0 = s_cnt;
    n_edge = 0;
    wr(BUF_OFS, {24'h0, tx}, RESP_OKAY);
    if (masked) begin
      wait (s_cnt == c0 + 1);
      repeat (4) @(posedge clk_sys_in);
      chk("masked irq", 0, irq_out);
    end else begin
      wait (irq_out === 1'b1);
      chk("edges at flag", 16, n_edge);
      chk("words at flag", c0 + 1, s_cnt);
    end
    wait (serial_clock_pin_out === s_idle);
    chk("slave word", tx, s_rx);
    rchk("stat", STAT_OFS, stat_exp(1'b1, 3'h0));
    rchk("rx word", BUF_OFS, s_tx);
    rchk("irq stat", IRQ_STAT_OFS, 32'h3);
    chk("irq cleared", 0, irq_out);
  endtask
  task automatic wrap_up();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rchk("ctrl", CTRL_OFS, 32'h0);
    rchk("stat", STAT_OFS, stat_exp(1'b0, 3'h0));
    chk("sck idle", 0, serial_clock_pin_out);
    rd(8'h18);
    chk("unmapped", {30'h0, RESP_SLVERR}, {rv[29:0], rr});
    wr(8'h1C, 32'hFFFFFFFF, RESP_SLVERR);
    wr(CTRL2_OFS, {17'h0, seed[14:0]}, RESP_OKAY);
    rchk("ctrl2", CTRL2_OFS, {17'h0, seed[14:0]});
    wr(CTRL_OFS, 32'h1, RESP_OKAY);
    xfer(1'b1);
    wr(IRQ_MASK_OFS, 32'h1, RESP_OKAY);
    // idle level only changes together with cke set, see the slave model
    for (int c = 0; c < 4; c++) begin
      {s_idle, s_cke} <= {c[1], c[0] ^ c[1]};
      wr(CTRL_OFS, {29'h0, c[1], c[0] ^ c[1], 1'b1}, RESP_OKAY);
      xfer(1'b0);
      xfer(1'b0);
    end
    // enhanced buffer: shift end versus fifo empty
    for (int m = 5; m <= 6; m++) begin
      wr(CTRL_OFS, 32'hD, RESP_OKAY);
      wr(STAT_OFS, m << 2, RESP_OKAY);
      rd(IRQ_STAT_OFS);
      c0 = s_cnt;
      n_edge = 0;
      seed = lfsr(seed);
      wr(BUF_OFS, {24'h0, seed[7:0]}, RESP_OKAY);
      wr(BUF_OFS, {24'h0, seed[15:8]}, RESP_OKAY);
      wait (irq_out === 1'b1);
      rd(STAT_OFS);
      chk("shift empty", m == 5, rv[7]);
      chk("words at flag", (m == 5) ? c0 + 2 : c0, s_cnt);
      wait (s_cnt == c0 + 2);
      wait (serial_clock_pin_out === s_idle);
      chk("slave word", seed[15:8], s_rx);
      rchk("irq stat", IRQ_STAT_OFS, 32'h3);
      rchk("rx word", BUF_OFS, s_tx);
    end
    for (int m = 0; m < 8; m++) begin
      wr(STAT_OFS, m << 2, RESP_OKAY);
      rchk("mode", STAT_OFS, stat_exp(1'b0, m[2:0]));
    end
    // fill the buffer: one word shifts, the buffer takes its depth, one more is dropped
    rd(IRQ_STAT_OFS);
    c0 = s_cnt;
    for (int w = 0; w < TX_DEPTH_DEF + 2; w++) begin
      seed = lfsr(seed);
      wr(BUF_OFS, {24'h0, seed[7:0]}, RESP_OKAY);
    end
    rchk("stat full", STAT_OFS, {24'h0, 1'b0, 2'h0, IRQ_MODE_TX_FULL, 1'b1, 1'b0});
    chk("full irq", 1, irq_out);
    wait (s_cnt == c0 + TX_DEPTH_DEF + 1);
    repeat (300) @(posedge clk_sys_in);
    chk("words sent", c0 + TX_DEPTH_DEF + 1, s_cnt);
    wrap_up();
  end
endmodule
